// File: hw/swfl_top.sv
// Protection latches, over-current profiles and register slave of the quad switch
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
// Summary of operation
// - Each output picks from eight limit levels; discharge, 55 W or 28 W profile.
// - Turn-on rising edge or auto-retry restarts the profile at its inrush steps.
// - Slope field sets step speed; skip bit drops the first, highest step.
// - Steady limit is low level two unless the select field picks one, three, four.
// - Over-current trip latches the output off and pulls the fault pin low.
// - Over-current latch clears when gone plus retry, off-on toggle, or supply reset.
// - Reading status clears the four over-current flags.
// - Cooling emulation picks the first step from off time; own slope field.
// - Severe short latches output off, fault pin low, sets its short flag.
// - Short latch ignores retry; clears only by off-on toggle, supply reset or mode change.
// - Reading status clears the four short flags.
// - Enabled over-voltage forces all outputs off and pin low; flag cleared on read.
// - Shutdown disable keeps only the warning flag, cleared on read once gone.
// - Under-voltage turns outputs off, pin low, sets flag; settings are kept.
// - Recovery with all commands low releases the pin; flag waits for a read.
// - Recovery with a command on keeps the pin low until the latch clears.
// - Extended range keeps latches, reports over-temperature, shuts off only below minimum.
// - Logic supply failure or full supply reset clears every latched fault.
// - Retry only in fault mode; request is over-current or over-temperature or under-voltage.
// - Retry re-enables after each period while requested; sixteen attempts at most.
// - Retry counters restart on any fail-safe and normal mode change.
// - Each retry restores default over-current settings to ride through inrush.
// - Over-temperature latches an on output off; off output holds pin only meanwhile.
module swfl_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [swfl_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [swfl_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [3:0] oc_trip,
	input wire logic [3:0] short_trip,
	input wire logic [3:0] overtemp,
	input wire logic overvolt,
	input wire logic undervolt,
	input wire logic ext_range,
	input wire logic batt_below_min,
	input wire logic vdd_fail,
	input wire logic supply_por,
	input wire logic fault_mode,
	input wire logic normal_mode,
	input wire logic pwm_internal,
	output logic [3:0] switch_output,
	output logic fault_flag_n,
	output swfl_pkg::swfl_oc_t [3:0] oc_sel
);
	logic [swfl_pkg::CTRL_W-1:0] ctrl_reg;
	logic [swfl_pkg::PROF_W-1:0] prof_reg;
	swfl_pkg::swfl_flags_t flags_reg;
	swfl_pkg::swfl_flags_t flags_set;
	logic aw_held_reg;
	logic w_held_reg;
	logic [swfl_pkg::ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic do_wr;
	logic rd_take;
	logic clr_stat;
	logic [31:0] rd_word;
	logic [31:0] wr_word;
	logic [31:0] ctrl_wr;
	logic [31:0] prof_wr;
	logic [swfl_pkg::DIV_W-1:0] div_reg;
	logic us_tick;
	logic normal_d_reg;
	logic mode_chg;
	logic clr_all;
	logic ov_ev;
	logic ov_stop;
	logic uv_ev;
	logic [3:0] cmd_on;
	logic [3:0] pin_low;
	logic [3:0] retry_exh;

	// True when an address falls in the same register word as the given offset
	function automatic logic map_hit(input logic [swfl_pkg::ADDR_W-1:0] a,
			input logic [swfl_pkg::ADDR_W-1:0] off);
		map_hit = (a[swfl_pkg::ADDR_W-1:2] == off[swfl_pkg::ADDR_W-1:2]);
	endfunction : map_hit

	function automatic logic mapped(input logic [swfl_pkg::ADDR_W-1:0] a);
		mapped = map_hit(a, swfl_pkg::ADDR_CTRL) || map_hit(a, swfl_pkg::ADDR_PROF) ||
			map_hit(a, swfl_pkg::ADDR_STAT) || map_hit(a, swfl_pkg::ADDR_STATE);
	endfunction : mapped

	// Byte-lane merge of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		merge = res;
	endfunction : merge

	// Steady DC level from the two-bit select; code zero is the default level two
	function automatic logic [2:0] steady_lvl(input logic [1:0] sel);
		case (sel)
			2'h1: steady_lvl = swfl_pkg::LVL_LO1;
			2'h2: steady_lvl = swfl_pkg::LVL_LO3;
			2'h3: steady_lvl = swfl_pkg::LVL_LO4;
			default: steady_lvl = swfl_pkg::LVL_LO2;
		endcase
	endfunction : steady_lvl

	// First inrush step from the off time; a long pause means a cold filament
	function automatic logic [1:0] cool_step(input logic [swfl_pkg::TMR_W-1:0] off_us,
			input logic [swfl_pkg::TMR_W-1:0] per);
		if ({2'h0, off_us} >= 18'(3) * {2'h0, per}) begin
			cool_step = 2'h0;
		end else if ({1'b0, off_us} >= {per, 1'b0}) begin
			cool_step = 2'h1;
		end else if (off_us >= per) begin
			cool_step = 2'h2;
		end else begin
			cool_step = swfl_pkg::STEP_LAST;
		end
	endfunction : cool_step

	// AXI4-Lite handshakes: address and data are held until both are in
	assign awready = !aw_held_reg && !bvalid_reg;
	assign wready = !w_held_reg && !bvalid_reg;
	assign arready = !rvalid_reg;
	assign do_wr = aw_held_reg && w_held_reg && !bvalid_reg;
	assign rd_take = arvalid && arready;
	assign clr_stat = rd_take && map_hit(araddr, swfl_pkg::ADDR_STAT);
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign wr_word = merge(32'h0000_0000, wdata_reg, wstrb_reg);
	// Merged words kept whole so the registers take a plain part-select
	assign ctrl_wr = merge({19'h0, ctrl_reg}, wr_word, wstrb_reg);
	assign prof_wr = merge({24'h0, prof_reg}, wr_word, wstrb_reg);

	// Write channel capture, in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= awaddr;
			end else if (do_wr) begin
				aw_held_reg <= 1'b0;
			end
			if (wvalid && wready) begin
				w_held_reg <= 1'b1;
				wdata_reg <= wdata;
				wstrb_reg <= wstrb;
			end else if (do_wr) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// Write response; status and state words are read only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= swfl_pkg::RESP_OKAY;
		end else if (do_wr) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= mapped(awaddr_reg) ? swfl_pkg::RESP_OKAY : swfl_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Configuration registers survive supply dips while the logic supply holds
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= swfl_pkg::CTRL_RST;
			prof_reg <= swfl_pkg::PROF_RST;
		end else if (do_wr && map_hit(awaddr_reg, swfl_pkg::ADDR_CTRL)) begin
			ctrl_reg <= ctrl_wr[swfl_pkg::CTRL_W-1:0];
		end else if (do_wr && map_hit(awaddr_reg, swfl_pkg::ADDR_PROF)) begin
			prof_reg <= prof_wr[swfl_pkg::PROF_W-1:0];
		end
	end

	// Read word selection; unused bits read as zero
	always_comb begin
		rd_word = 32'h0000_0000;
		if (map_hit(araddr, swfl_pkg::ADDR_CTRL)) begin
			rd_word[swfl_pkg::CTRL_W-1:0] = ctrl_reg;
		end else if (map_hit(araddr, swfl_pkg::ADDR_PROF)) begin
			rd_word[swfl_pkg::PROF_W-1:0] = prof_reg;
		end else if (map_hit(araddr, swfl_pkg::ADDR_STAT)) begin
			rd_word[13:0] = flags_reg;
		end else if (map_hit(araddr, swfl_pkg::ADDR_STATE)) begin
			rd_word[13:0] = {retry_exh, 5'h00, fault_flag_n, switch_output};
		end
	end

	// Read data channel, answered from flip-flops one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= swfl_pkg::RESP_OKAY;
		end else if (rd_take) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_word;
			rresp_reg <= mapped(araddr) ? swfl_pkg::RESP_OKAY : swfl_pkg::RESP_SLVERR;
		end else if (rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// Microsecond enable pulse for all profile, cooling and retry timers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_reg <= '0;
		end else if (div_reg == swfl_pkg::DIV_LAST) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 5'h01;
		end
	end
	assign us_tick = (div_reg == swfl_pkg::DIV_LAST);

	// Mode change detector feeds the retry counters and the latch clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			normal_d_reg <= normal_mode; // No false mode change right after reset
		end else begin
			normal_d_reg <= normal_mode;
		end
	end
	assign mode_chg = normal_mode ^ normal_d_reg;

	// Supply events shared by all outputs
	assign clr_all = vdd_fail || supply_por || mode_chg;
	assign ov_ev = overvolt;
	assign ov_stop = ov_ev && !ctrl_reg[swfl_pkg::CTRL_OVOFF];
	// In extended range only the lower battery limit shuts outputs down
	assign uv_ev = ext_range ? batt_below_min : undervolt;
	assign cmd_on = ctrl_reg[swfl_pkg::CTRL_ON_LSB +: 4];

	// Shared flag sets; over-voltage keeps setting while present, so a read cannot clear it
	assign flags_set.ov = ov_ev;
	assign flags_set.uv = uv_ev;

	// Sticky flags: a set in the same cycle as a clearing read wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_reg <= '0;
		end else if (clr_all) begin
			flags_reg <= '0;
		end else if (clr_stat) begin
			flags_reg <= flags_set;
		end else begin
			flags_reg <= flags_reg | flags_set;
		end
	end

	// Fault pin: low while any output or shared condition holds it
	assign fault_flag_n = !(|pin_low || ov_stop || uv_ev);

	// Per-output protection channel
	for (genvar i = 0; i < swfl_pkg::NCH; i++) begin : g_ch
		logic on_d_reg;
		logic rise;
		logic restart;
		logic fire;
		logic oc_lat_reg;
		logic sc_lat_reg;
		logic ot_lat_reg;
		logic uv_lat_reg;
		logic dflt_reg;
		logic cool_ok;
		logic [1:0] slope;
		logic [1:0] start;
		logic [1:0] step_reg;
		logic [swfl_pkg::TMR_W-1:0] dwell_reg;
		logic [swfl_pkg::TMR_W-1:0] off_reg;
		swfl_pkg::swfl_prof_state_t st_reg;

		assign rise = cmd_on[i] && !on_d_reg;
		assign restart = rise || fire;

		// Command edge detector
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				on_d_reg <= 1'b0;
			end else begin
				on_d_reg <= cmd_on[i];
			end
		end

		// Fault latches: supply or mode clear wins; otherwise set has priority, clear needs the condition gone
		always_ff @(posedge aclk) begin
			if (!aresetn || clr_all) begin
				oc_lat_reg <= 1'b0;
				sc_lat_reg <= 1'b0;
				ot_lat_reg <= 1'b0;
				uv_lat_reg <= 1'b0;
			end else begin
				if (oc_trip[i] && switch_output[i]) begin
					oc_lat_reg <= 1'b1;
				end else if (restart) begin
					oc_lat_reg <= 1'b0;
				end
				if (short_trip[i] && switch_output[i]) begin
					sc_lat_reg <= 1'b1;
				end else if (rise) begin
					sc_lat_reg <= 1'b0;
				end
				if (overtemp[i] && cmd_on[i]) begin
					ot_lat_reg <= 1'b1;
				end else if (restart) begin
					ot_lat_reg <= 1'b0;
				end
				if (uv_ev && cmd_on[i]) begin
					uv_lat_reg <= 1'b1;
				end else if (restart) begin
					uv_lat_reg <= 1'b0;
				end
			end
		end

		// Output drive; over-voltage and under-voltage act without waiting for a latch
		assign switch_output[i] = cmd_on[i] && !oc_lat_reg && !sc_lat_reg && !ot_lat_reg &&
			!uv_lat_reg && !ov_stop && !uv_ev;
		// Hot but off output holds the pin only while hot; uv latch counts only when on
		assign pin_low[i] = oc_lat_reg || sc_lat_reg || ot_lat_reg || overtemp[i] ||
			(uv_lat_reg && cmd_on[i]);

		// Flag sets for this output
		assign flags_set.oc[i] = oc_trip[i] && switch_output[i];
		assign flags_set.sc[i] = short_trip[i] && switch_output[i];
		assign flags_set.ot[i] = overtemp[i];

		swfl_retry u_retry (
			.aclk(aclk),
			.aresetn(aresetn),
			.us_tick(us_tick),
			.enable(fault_mode),
			.request(flags_reg.oc[i] || flags_reg.ot[i] || flags_reg.uv),
			.mode_change(mode_chg),
			.attempt(fire),
			.exhausted(retry_exh[i]),
			.count()
		);

		// Defaults after a retry hold until the host toggles the command again
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				dflt_reg <= 1'b0;
			end else if (fire) begin
				dflt_reg <= 1'b1;
			end else if (rise) begin
				dflt_reg <= 1'b0;
			end
		end

		assign slope = dflt_reg ? 2'h0 : ctrl_reg[swfl_pkg::CTRL_SLOPE_LSB +: 2];
		assign cool_ok = !dflt_reg && normal_mode && pwm_internal && ctrl_reg[swfl_pkg::CTRL_COOL] &&
			prof_reg[swfl_pkg::PROF_HID_LSB + i];

		// First step: cooling estimate, then the skip-first-peak option
		always_comb begin
			start = 2'h0;
			if (cool_ok) begin
				start = cool_step(off_reg, swfl_pkg::COOL_US[ctrl_reg[swfl_pkg::CTRL_CSLOPE_LSB +: 2]]);
			end
			if (!dflt_reg && ctrl_reg[swfl_pkg::CTRL_SKIP] && start == 2'h0) begin
				start = 2'h1;
			end
		end

		// Off-time counter, saturating, for the cooling emulation
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				off_reg <= '1;
			end else if (switch_output[i]) begin
				off_reg <= '0;
			end else if (us_tick && off_reg != '1) begin
				off_reg <= off_reg + 16'h0001;
			end
		end

		// Profile sequencer: inrush steps on the slope timer, then the steady level
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				st_reg <= swfl_pkg::PR_OFF;
				step_reg <= 2'h0;
				dwell_reg <= '0;
			end else if (restart) begin
				st_reg <= swfl_pkg::PR_INRUSH;
				step_reg <= start;
				dwell_reg <= '0;
			end else begin
				case (st_reg)
					swfl_pkg::PR_INRUSH: begin
						if (!cmd_on[i]) begin
							st_reg <= swfl_pkg::PR_OFF;
						end else if (us_tick && dwell_reg == swfl_pkg::STEP_US[slope] - 16'h0001) begin
							dwell_reg <= '0;
							if (step_reg == swfl_pkg::STEP_LAST) begin
								st_reg <= swfl_pkg::PR_STEADY;
							end else begin
								step_reg <= step_reg + 2'h1;
							end
						end else if (us_tick) begin
							dwell_reg <= dwell_reg + 16'h0001;
						end
					end
					swfl_pkg::PR_STEADY: begin
						if (!cmd_on[i]) begin
							st_reg <= swfl_pkg::PR_OFF;
						end
					end
					default: begin
						st_reg <= swfl_pkg::PR_OFF;
					end
				endcase
			end
		end

		// Level and profile selection toward the comparator bank
		always_comb begin
			oc_sel[i].level = steady_lvl(dflt_reg ? 2'h0 : ctrl_reg[swfl_pkg::CTRL_STEADY_LSB +: 2]);
			if (st_reg == swfl_pkg::PR_INRUSH) begin
				oc_sel[i].level = {1'b0, step_reg};
			end
			if (prof_reg[swfl_pkg::PROF_HID_LSB + i]) begin
				oc_sel[i].profile = swfl_pkg::PROF_HID;
			end else if (prof_reg[swfl_pkg::PROF_28W_LSB + i]) begin
				oc_sel[i].profile = swfl_pkg::PROF_28W;
			end else begin
				oc_sel[i].profile = swfl_pkg::PROF_55W;
			end
		end
	end
endmodule : swfl_top

// File: hw/swfl_pkg.sv
// Constants, field layouts and carrier types for the switch fault latch block
package swfl_pkg;
	// Clock and the microsecond time base
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned US_PER_S = 1_000_000;
	localparam int unsigned US_CYCLES = CLK_HZ / US_PER_S;
	localparam int unsigned DIV_W = 5;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(US_CYCLES - 1);

	// Channel count and timer widths
	localparam int unsigned NCH = 4;
	localparam int unsigned TMR_W = 16;
	localparam int unsigned RCNT_W = 5;

	// Auto-retry period in microseconds and attempt limit per output
	localparam logic [TMR_W-1:0] RETRY_US = 16'h00C8;
	localparam logic [RCNT_W-1:0] RETRY_MAX = 5'h10;

	// Dwell of each inrush step in microseconds, indexed by slope select
	localparam logic [TMR_W-1:0] STEP_US [4] = '{16'h0200, 16'h0400, 16'h0800, 16'h1000};
	// Cooling emulation period in microseconds, indexed by cooling slope select
	localparam logic [TMR_W-1:0] COOL_US [4] = '{16'h0800, 16'h1000, 16'h2000, 16'h4000};

	// Register byte addresses and address width
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_PROF = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h0C;

	// Control register layout and reset value
	localparam int unsigned CTRL_W = 13;
	localparam int unsigned CTRL_ON_LSB = 0;
	localparam int unsigned CTRL_OVOFF = 4;
	localparam int unsigned CTRL_SKIP = 5;
	localparam int unsigned CTRL_SLOPE_LSB = 6;
	localparam int unsigned CTRL_STEADY_LSB = 8;
	localparam int unsigned CTRL_COOL = 10;
	localparam int unsigned CTRL_CSLOPE_LSB = 11;
	localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;

	// Profile register layout and reset value (discharge profile on all outputs)
	localparam int unsigned PROF_W = 8;
	localparam int unsigned PROF_HID_LSB = 0;
	localparam int unsigned PROF_28W_LSB = 4;
	localparam logic [PROF_W-1:0] PROF_RST = 8'h0F;

	// Profile codes presented to the comparator bank
	localparam logic [1:0] PROF_HID = 2'h0;
	localparam logic [1:0] PROF_55W = 2'h1;
	localparam logic [1:0] PROF_28W = 2'h2;

	// Level indices: 0..3 inrush steps, 4..7 low DC levels one to four
	localparam logic [1:0] STEP_LAST = 2'h3;
	localparam logic [2:0] LVL_LO1 = 3'h4;
	localparam logic [2:0] LVL_LO2 = 3'h5;
	localparam logic [2:0] LVL_LO3 = 3'h6;
	localparam logic [2:0] LVL_LO4 = 3'h7;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Sticky fault flags as seen in the status register
	typedef struct packed {
		logic uv;
		logic ov;
		logic [NCH-1:0] ot;
		logic [NCH-1:0] sc;
		logic [NCH-1:0] oc;
	} swfl_flags_t;

	// Over-current selection handed to one output's comparator
	typedef struct packed {
		logic [1:0] profile;
		logic [2:0] level;
	} swfl_oc_t;

	// Over-current profile sequencer states
	typedef enum logic [1:0] {PR_OFF, PR_INRUSH, PR_STEADY} swfl_prof_state_t;
endpackage : swfl_pkg

// File: hw/swfl_retry.sv
// Auto-retry timer and attempt counter for one output
`timescale 1ns/100ps
module swfl_retry (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic us_tick,
	input wire logic enable,
	input wire logic request,
	input wire logic mode_change,
	output logic attempt,
	output logic exhausted,
	output logic [swfl_pkg::RCNT_W-1:0] count
);
	logic [swfl_pkg::TMR_W-1:0] tmr_reg;
	logic [swfl_pkg::RCNT_W-1:0] cnt_reg;
	logic active;
	logic due;

	// Retry runs only in fault mode and only while the limit is not used up
	assign active = enable && request && (cnt_reg < swfl_pkg::RETRY_MAX);
	assign due = active && us_tick && (tmr_reg == swfl_pkg::RETRY_US - 16'h0001);
	assign attempt = due;
	assign exhausted = (cnt_reg == swfl_pkg::RETRY_MAX);
	assign count = cnt_reg;

	// Period timer restarts at each attempt and whenever the request drops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tmr_reg <= '0;
		end else if (!active || due) begin
			tmr_reg <= '0;
		end else if (us_tick) begin
			tmr_reg <= tmr_reg + 16'h0001;
		end
	end

	// Attempt counter; a mode change wins so a fresh budget follows it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg <= '0;
		end else if (mode_change) begin
			cnt_reg <= '0;
		end else if (due) begin
			cnt_reg <= cnt_reg + 5'h01;
		end
	end
endmodule : swfl_retry

// File: testbench/swfl_props.sv
// Port-level assertions for the switch fault latch top
`timescale 1ns/100ps
module swfl_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [3:0] oc_trip,
	input wire logic [3:0] short_trip,
	input wire logic undervolt,
	input wire logic ext_range,
	input wire logic vdd_fail,
	input wire logic supply_por,
	input wire logic [3:0] switch_output,
	input wire logic fault_flag_n
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Supply clears are excluded: they may wipe a latch in the same edge
	chk_oc_latch: assert property (|oc_trip && !vdd_fail && !supply_por
		|=> !fault_flag_n && (switch_output & $past(oc_trip)) == 4'h0) else $error("oc not latched");
	chk_short_latch: assert property (|short_trip && !vdd_fail && !supply_por
		|=> !fault_flag_n && (switch_output & $past(short_trip)) == 4'h0) else $error("sc not latched");
	chk_uv_off: assert property (undervolt && !ext_range
		|-> switch_output == 4'h0 && !fault_flag_n) else $error("uv left outputs on");
	chk_b_hold: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
	chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("r moved");
	chk_w_resp: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("no write response");
	chk_r_resp: assert property (arvalid && arready |=> rvalid) else $error("no read data");
	chk_ar_busy: assert property (rvalid |-> !arready) else $error("ar taken while busy");
endmodule : swfl_props

// File: testbench/swfl_load_model.sv
// Load comparator model: trips only while its output conducts
`timescale 1ns/100ps
module swfl_load_model (
	input wire logic [3:0] switch_output,
	input wire logic [3:0] overload,
	input wire logic [3:0] shorted,
	output logic [3:0] oc_trip,
	output logic [3:0] short_trip
);
	// An open switch draws no current, so a fault vanishes once latched off
	assign oc_trip = switch_output & overload;
	assign short_trip = switch_output & shorted;
endmodule : swfl_load_model

// File: testbench/testbench.sv
// Self-checking bench for the switch fault latch top
`timescale 1ns/100ps
module testbench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, got;
	logic [1:0] bresp, rresp;
	logic [3:0] overload, shorted, overtemp, oc_trip, short_trip, switch_output;
	logic overvolt, undervolt, vdd_fail, supply_por, fault_mode, fault_flag_n;
	swfl_pkg::swfl_oc_t [3:0] oc_sel;
	int n_errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	always #25 aclk = ~aclk;
	swfl_top swfl_top_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .oc_trip, .short_trip, .overtemp, .overvolt, .undervolt,
		.ext_range(1'b0), .batt_below_min(1'b0), .vdd_fail, .supply_por, .fault_mode,
		.normal_mode(1'b1), .pwm_internal(1'b0), .switch_output, .fault_flag_n, .oc_sel);
	swfl_load_model swfl_load_model_i (.switch_output, .overload, .shorted, .oc_trip, .short_trip);
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// Handshakes are judged at the falling edge, acted on at the next rising one
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		tb = 1'b0;
		@(posedge aclk);
		{awaddr, wdata} <= {a, d};
		{awvalid, wvalid, bready} <= 3'h7;
		while (!tb) begin
			@(negedge aclk);
			{ta, tw, tb} = {awvalid & awready, wvalid & wready, bvalid};
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
		end
		@(negedge aclk);
	endtask : wr
	task rd(input logic [7:0] a);
		logic ta, tr;
		tr = 1'b0;
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		while (!tr) begin
			@(negedge aclk);
			{ta, tr, got} = {arvalid & arready, rvalid, rdata};
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
		end
		@(negedge aclk);
	endtask : rd
	task t_reset;
		rd(swfl_pkg::ADDR_PROF);
		chk(got, 32'h0000_000F);
		chk(32'(oc_sel[0]), 32'({swfl_pkg::PROF_HID, swfl_pkg::LVL_LO2}));
		rd(8'h10);
		chk(got, 32'h0);
		chk(32'(rresp), 32'(swfl_pkg::RESP_SLVERR));
		wr(swfl_pkg::ADDR_PROF, 32'h0000_0000);
		chk(32'(bresp), 32'(swfl_pkg::RESP_OKAY));
		chk(32'(oc_sel[0].profile), 32'(swfl_pkg::PROF_55W));
		wr(swfl_pkg::ADDR_PROF, 32'h0000_0010);
		chk(32'(oc_sel[0].profile), 32'(swfl_pkg::PROF_28W));
		wr(swfl_pkg::ADDR_PROF, 32'h0000_000F);
	endtask : t_reset
	// Over-current on output 0, then a severe short on output 1
	task t_latch;
		for (int k = 0; k < 2; k++) begin
			wr(swfl_pkg::ADDR_CTRL, 32'(1 << k));
			@(posedge aclk);
			{overload, shorted} <= (k == 0) ? 8'h10 : 8'h02;
			repeat (3) @(posedge aclk);
			{overload, shorted} <= 8'h00;
			@(negedge aclk);
			chk(32'({fault_flag_n, switch_output}), 32'h0);
			rd(swfl_pkg::ADDR_STAT);
			chk(got, 32'(1 << (5 * k)));
			rd(swfl_pkg::ADDR_STAT);
			chk(got, 32'h0);
			wr(swfl_pkg::ADDR_CTRL, 32'h0);
			wr(swfl_pkg::ADDR_CTRL, 32'(1 << k));
			chk(32'({fault_flag_n, switch_output}), 32'(16 + (1 << k)));
		end
	endtask : t_latch
	task t_ov;
		for (int k = 0; k < 2; k++) begin
			wr(swfl_pkg::ADDR_CTRL, 32'(15 + 16 * k));
			@(posedge aclk);
			overvolt <= 1'b1;
			@(negedge aclk);
			chk(32'({fault_flag_n, switch_output}), 32'(31 * k));
			@(posedge aclk);
			overvolt <= 1'b0;
			rd(swfl_pkg::ADDR_STAT);
			chk(got, 32'h0000_1000);
			rd(swfl_pkg::ADDR_STAT);
			chk(32'({got, fault_flag_n, switch_output}), 32'h1F);
		end
	endtask : t_ov
	task t_uv_ot;
		wr(swfl_pkg::ADDR_CTRL, 32'h0000_0100);
		@(posedge aclk);
		undervolt <= 1'b1;
		rd(swfl_pkg::ADDR_CTRL);
		chk(got, 32'h0000_0100);
		chk(32'(oc_sel[1].level), 32'(swfl_pkg::LVL_LO1));
		@(posedge aclk);
		undervolt <= 1'b0;
		overtemp <= 4'h8;
		@(negedge aclk);
		chk(32'(fault_flag_n), 32'h0);
		@(posedge aclk);
		overtemp <= 4'h0;
		@(negedge aclk);
		chk(32'(fault_flag_n), 32'h1);
		rd(swfl_pkg::ADDR_STAT);
		chk(got, 32'h0000_2800);
	endtask : t_uv_ot
	// Logic supply failure, then full power-on, each wipes a live latch
	task t_clear;
		wr(swfl_pkg::ADDR_CTRL, 32'h1);
		for (int k = 0; k < 2; k++) begin
			@(posedge aclk);
			overload <= 4'h1;
			repeat (3) @(posedge aclk);
			overload <= 4'h0;
			{vdd_fail, supply_por} <= (k == 0) ? 2'h2 : 2'h1;
			@(posedge aclk);
			{vdd_fail, supply_por} <= 2'h0;
			@(negedge aclk);
			chk(32'({fault_flag_n, switch_output}), 32'h11);
			rd(swfl_pkg::ADDR_STAT);
			chk(got, 32'h0);
		end
	endtask : t_clear
	task t_retry;
		int n;
		n = 0;
		@(posedge aclk);
		fault_mode <= 1'b1;
		wr(swfl_pkg::ADDR_CTRL, 32'h4);
		@(posedge aclk);
		overload <= 4'h4;
		repeat (3) @(posedge aclk);
		overload <= 4'h0;
		@(negedge aclk);
		while (!switch_output[2] && n < 5000) begin
			@(negedge aclk);
			n++;
		end
		chk(32'(switch_output), 32'h4);
		chk(32'(oc_sel[2].level), 32'h0);
	endtask : t_retry
	task complete_run;
		$display("Checks %0d, errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	// A hang is cut short well beyond the longest retry wait
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			complete_run;
		end
	end
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		{overload, shorted, overtemp} = '0;
		{overvolt, undervolt, vdd_fail, supply_por, fault_mode} = '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_latch;
		t_ov;
		t_uv_ot;
		t_clear;
		t_retry;
		complete_run;
	end
endmodule : testbench
bind swfl_top swfl_props swfl_props_i (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
	.bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata, .oc_trip, .short_trip,
	.undervolt, .ext_range, .vdd_fail, .supply_por, .switch_output, .fault_flag_n);
